// file: inc/lcr_pkg.sv
// Constants for the lane C/D configuration register bank.
// Assumes one device clock; APB byte address = register index * 4.
package lcr_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam int         ADDR_W        = 8;
   localparam int         DATA_W        = 32;
   localparam int         REG_W         = 16;
   localparam int         NUM_LANES     = 2;
   localparam logic [7:0] LANE_C_IDX    = 8'h13;
   localparam logic [7:0] LANE_D_IDX    = 8'h14;
   localparam logic [7:0] LANE_STAT_IDX = 8'h16;
   localparam logic [7:0] LANE_C_ADDR   = 8'((10'(LANE_C_IDX) << 2));
   localparam logic [7:0] LANE_D_ADDR   = 8'((10'(LANE_D_IDX) << 2));
   localparam logic [7:0] LANE_STAT_ADDR = 8'((10'(LANE_STAT_IDX) << 2));

   // ----------------------------------------------------------------
   // Lane configuration fields
   // ----------------------------------------------------------------
   localparam int BIT_CTC     = 11;
   localparam int BIT_AUX_HI  = 10;
   localparam int BIT_AUX_LO  = 9;
   localparam int BIT_SIGDET  = 8;
   localparam int BIT_CFG1    = 7;
   localparam int BIT_CFG0    = 6;
   localparam int BIT_EMPH_HI = 5;
   localparam int BIT_EMPH_LO = 4;
   localparam int BIT_LOOP    = 3;
   localparam int BIT_PAT     = 2;
   localparam int BIT_ALIGN   = 1;
   localparam int BIT_PDN     = 0;
   localparam logic [15:0] LANE_RST     = 16'h0102;
   localparam logic [15:0] LANE_WR_MASK = 16'h0fff;

   // Bits of the base control register feeding lane controls
   localparam int BASE_LOOP = 14;
   localparam int BASE_PDN  = 11;

   // ----------------------------------------------------------------
   // Lane status register fields (lane 0 = C, lane 1 = D)
   // ----------------------------------------------------------------
   localparam int STAT_LOST_BASE = 2;
   localparam int STAT_PASS_BASE = 6;

   // ----------------------------------------------------------------
   // Auxiliary pin source select
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      AUX_IOSTD = 2'b00,
      AUX_COMMA = 2'b01,
      AUX_LOST  = 2'b10,
      AUX_PASS  = 2'b11
   } lcr_aux_t;

endpackage : lcr_pkg

// file: logic/lcr_lane.sv
// One lane configuration register and its effective controls.
// Assumes writes are already decoded and qualified by the APB slave.
`timescale 1ns/1ps
`default_nettype none
module lcr_lane
   import lcr_pkg::*;
(
   input  wire logic             ref_clk,          // Device clock
   input  wire logic             arst_n,           // Async reset, active low
   input  wire logic             wr_en,            // Write strobe for this lane
   input  wire logic [REG_W-1:0] wr_data,          // Write data
   input  wire logic [REG_W-1:0] glob_cfg,         // Global lane config register
   input  wire logic [REG_W-1:0] base_ctrl,        // Base control register
   input  wire logic             cfg_strap_high_bit, // Strap locking bit 7
   input  wire logic             cfg_strap_low_bit,  // Strap locking bit 6
   input  wire logic             pattern_test_pin, // Locks bit 2
   input  wire logic             align_enable_pin, // Alignment enable pin
   input  wire logic [3:0]       aux_src,          // Aux pin sources by code
   output logic [REG_W-1:0]      cfg_q,            // Stored register value
   output logic                  ctc_en,           // Clock tolerance comp
   output logic [1:0]            aux_sel,          // Effective aux select
   output logic                  aux_pin,          // Auxiliary pin drive
   output logic                  sig_det_en,       // Signal-absent detect enable
   output logic [1:0]            cfg_mode,         // Configuration pair
   output logic [1:0]            emph,             // Pre-emphasis
   output logic                  loopback,         // Loopback enable
   output logic                  pattern_en,       // Pattern test enable
   output logic                  align_en,         // Comma align enable
   output logic                  power_down        // Lane power-down
);

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   logic [REG_W-1:0] cfg_r;
   logic [REG_W-1:0] cfg_nxt;
   logic [REG_W-1:0] hold_mask;

   // Strap-locked bits keep their stored value
   assign hold_mask = (REG_W'(cfg_strap_high_bit) << BIT_CFG1)
                    | (REG_W'(cfg_strap_low_bit) << BIT_CFG0)
                    | (REG_W'(pattern_test_pin) << BIT_PAT);
   assign cfg_nxt   = wr_en ? ((wr_data & LANE_WR_MASK & ~hold_mask)
                             | (cfg_r & hold_mask))
                            : cfg_r;

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         cfg_r <= LANE_RST;
      end else begin
         cfg_r <= cfg_nxt;
      end
   end

   assign cfg_q = cfg_r;

   // ----------------------------------------------------------------
   // Effective controls
   // ----------------------------------------------------------------
   assign ctc_en     = cfg_r[BIT_CTC] | glob_cfg[BIT_CTC];
   assign aux_sel    = cfg_r[BIT_AUX_HI:BIT_AUX_LO] | glob_cfg[BIT_AUX_HI:BIT_AUX_LO];
   assign aux_pin    = aux_src[aux_sel];
   assign sig_det_en = cfg_r[BIT_SIGDET] & glob_cfg[BIT_SIGDET];
   assign cfg_mode   = cfg_r[BIT_CFG1:BIT_CFG0] | glob_cfg[BIT_CFG1:BIT_CFG0];
   assign emph       = cfg_r[BIT_EMPH_HI:BIT_EMPH_LO] | glob_cfg[BIT_EMPH_HI:BIT_EMPH_LO];
   assign loopback   = cfg_r[BIT_LOOP] | base_ctrl[BASE_LOOP];
   assign pattern_en = cfg_r[BIT_PAT] | glob_cfg[BIT_PAT];
   assign align_en   = cfg_r[BIT_ALIGN] & align_enable_pin & glob_cfg[BIT_ALIGN];
   assign power_down = cfg_r[BIT_PDN] | base_ctrl[BASE_PDN];

endmodule : lcr_lane
`default_nettype wire

// file: logic/lcr_regs.sv
// Lane C/D configuration register bank with APB slave and lane status.
// Assumes global config, base control, straps and lane events are synchronous.
//
// Functional notes
// - Lane C config at index 19, lane D at index 20, same 16-bit layout.
// - Bits 15:12 reserved: read zero, writes ignored.
// - Bit 11 clock tolerance compensation, default 0, ORed with global bit 11.
// - Lane C aux select: I/O standard, comma, lost flag C, pass flag C.
// - Lane D aux select alike, routing lost flag D and pass flag D.
// - Effective aux select is lane bits 10:9 ORed with global bits 10:9.
// - Bit 8 signal-absent detect, default 1, ANDed with global bit 8.
// - Bits 7,6 default 0, ORed with global; locked while their strap is high.
// - Bits 5,4 pre-emphasis, default 0, ORed with global bits 5,4.
// - Bit 3 loopback, default 0, ORed with base control bit 14.
// - Bit 2 pattern test, ORed with global bit 2; locked while pin high.
// - Bit 1 comma align, default 1, ANDed with align pin and global bit 1.
// - Bit 0 power-down, default 0, ORed with base control bit 11.
// - Lane signal-lost status reads 1 when reported, clears after being read.
`timescale 1ns/1ps
`default_nettype none
module lcr_regs
   import lcr_pkg::*;
(
   input  wire logic                  ref_clk,            // 40 MHz device clock
   input  wire logic                  arst_n,             // Async reset, active low
   input  wire logic                  psel,               // APB select
   input  wire logic                  penable,            // APB enable
   input  wire logic                  pwrite,             // APB write
   input  wire logic [ADDR_W-1:0]     paddr,              // APB byte address
   input  wire logic [DATA_W-1:0]     pwdata,             // APB write data
   output logic [DATA_W-1:0]          prdata,             // APB read data
   output logic                       pready,             // APB ready
   output logic                       pslverr,            // APB error
   input  wire logic [REG_W-1:0]      glob_cfg,           // Global lane config register
   input  wire logic [REG_W-1:0]      base_ctrl,          // Base control register
   input  wire logic                  cfg_strap_high_bit, // Strap pin, config high
   input  wire logic                  cfg_strap_low_bit,  // Strap pin, config low
   input  wire logic                  pattern_test_pin,   // Pattern test pin
   input  wire logic                  align_enable_pin,   // Alignment enable pin
   input  wire logic                  io_std_hstl,        // 1 HSTL, 0 SSTL_2
   input  wire logic [NUM_LANES-1:0]  comma_det,          // Comma detected, per lane
   input  wire logic [NUM_LANES-1:0]  signal_absent_evt,  // Signal lost event, per lane
   input  wire logic [NUM_LANES-1:0]  pattern_pass,       // Pattern test pass, per lane
   output logic                       aux_pin_c,          // Lane C auxiliary pin
   output logic                       aux_pin_d,          // Lane D auxiliary pin
   output logic [NUM_LANES-1:0]       ctc_en,             // Clock tolerance comp enable
   output logic [NUM_LANES-1:0]       sig_det_en,         // Signal-absent detect enable
   output logic [2*NUM_LANES-1:0]     cfg_mode,           // Config pair, lane D high
   output logic [2*NUM_LANES-1:0]     emph,               // Pre-emphasis, lane D high
   output logic [NUM_LANES-1:0]       loopback,           // Loopback enable
   output logic [NUM_LANES-1:0]       pattern_en,         // Pattern test enable
   output logic [NUM_LANES-1:0]       align_en,           // Comma align enable
   output logic [NUM_LANES-1:0]       power_down          // Lane power-down
);

   // ----------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------
   wire logic             setup_ph   = psel & ~penable;
   wire logic             access_ph  = psel & penable;
   wire logic             hit_c      = (paddr == LANE_C_ADDR);
   wire logic             hit_d      = (paddr == LANE_D_ADDR);
   wire logic             hit_stat   = (paddr == LANE_STAT_ADDR);
   wire logic             hit_any    = hit_c | hit_d | hit_stat;
   wire logic             wr_ok      = access_ph & pwrite;
   wire logic             stat_rd    = access_ph & ~pwrite & hit_stat;
   wire logic [NUM_LANES-1:0] lane_wr = {wr_ok & hit_d, wr_ok & hit_c};

   assign pready = 1'b1;

   // ----------------------------------------------------------------
   // Lane status: sticky signal-lost, live pattern pass
   // ----------------------------------------------------------------
   logic [NUM_LANES-1:0] lost_r;
   logic [NUM_LANES-1:0] lost_nxt;
   logic [NUM_LANES-1:0] lost_taken_r;
   logic [NUM_LANES-1:0] lost_taken_nxt;
   logic [REG_W-1:0]     stat_word;
   logic [REG_W-1:0]     cfg_q [NUM_LANES];
   logic [1:0]           aux_sel [NUM_LANES];
   logic [NUM_LANES-1:0] aux_out;

   // Only bits captured into read data are cleared; a new event wins
   assign lost_nxt       = (lost_r & ~(stat_rd ? lost_taken_r : '0)) | signal_absent_evt;
   assign lost_taken_nxt = (setup_ph & ~pwrite & hit_stat) ? lost_r : lost_taken_r;
   assign stat_word      = REG_W'((REG_W'(lost_r) << STAT_LOST_BASE)
                         | (REG_W'(pattern_pass) << STAT_PASS_BASE));

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         lost_r       <= '0;
         lost_taken_r <= '0;
      end else begin
         lost_r       <= lost_nxt;
         lost_taken_r <= lost_taken_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Lanes
   // ----------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < NUM_LANES; g++) begin : g_lane
         logic [3:0] src;
         assign src[AUX_IOSTD] = io_std_hstl;
         assign src[AUX_COMMA] = comma_det[g];
         assign src[AUX_LOST]  = lost_r[g];
         assign src[AUX_PASS]  = pattern_pass[g];
         lcr_lane u_lane (
            .ref_clk            (ref_clk),
            .arst_n             (arst_n),
            .wr_en              (lane_wr[g]),
            .wr_data            (pwdata[REG_W-1:0]),
            .glob_cfg           (glob_cfg),
            .base_ctrl          (base_ctrl),
            .cfg_strap_high_bit (cfg_strap_high_bit),
            .cfg_strap_low_bit  (cfg_strap_low_bit),
            .pattern_test_pin   (pattern_test_pin),
            .align_enable_pin   (align_enable_pin),
            .aux_src            (src),
            .cfg_q              (cfg_q[g]),
            .ctc_en             (ctc_en[g]),
            .aux_sel            (aux_sel[g]),
            .aux_pin            (aux_out[g]),
            .sig_det_en         (sig_det_en[g]),
            .cfg_mode           (cfg_mode[2*g +: 2]),
            .emph               (emph[2*g +: 2]),
            .loopback           (loopback[g]),
            .pattern_en         (pattern_en[g]),
            .align_en           (align_en[g]),
            .power_down         (power_down[g])
         );
      end
   endgenerate

   assign aux_pin_c = aux_out[0];
   assign aux_pin_d = aux_out[1];

   // ----------------------------------------------------------------
   // Read data and error, captured in the setup cycle
   // ----------------------------------------------------------------
   logic [DATA_W-1:0] prdata_r;
   logic [DATA_W-1:0] prdata_nxt;
   logic              pslverr_r;
   logic              pslverr_nxt;
   wire  logic [REG_W-1:0] rd_word = hit_c    ? cfg_q[0]
                                   : hit_d    ? cfg_q[1]
                                   : hit_stat ? stat_word
                                   : '0;

   assign prdata_nxt  = (setup_ph & ~pwrite) ? DATA_W'(rd_word) : prdata_r;
   assign pslverr_nxt = setup_ph ? ~hit_any : pslverr_r;

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         prdata_r  <= '0;
         pslverr_r <= 1'b0;
      end else begin
         prdata_r  <= prdata_nxt;
         pslverr_r <= pslverr_nxt;
      end
   end

   assign prdata  = prdata_r;
   assign pslverr = pslverr_r & access_ph;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);

   property p_wr_lane_c;
      wr_ok && hit_c && !cfg_strap_high_bit && !cfg_strap_low_bit && !pattern_test_pin
      |=> cfg_q[0] == ($past(pwdata[REG_W-1:0]) & LANE_WR_MASK);
   endproperty
   a_wr_lane_c: assert property (p_wr_lane_c) else $error("lane C write not stored");

   property p_rsvd_zero;
      setup_ph && !pwrite && (hit_c || hit_d) ##1 access_ph |-> prdata[DATA_W-1:12] == '0;
   endproperty
   a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits read nonzero");

   property p_ctc;
      ctc_en[1] == (cfg_q[1][BIT_CTC] | glob_cfg[BIT_CTC]);
   endproperty
   a_ctc: assert property (p_ctc) else $error("ctc enable wrong");

   property p_aux_c;
      aux_sel[0] == AUX_LOST |-> aux_pin_c == lost_r[0];
   endproperty
   a_aux_c: assert property (p_aux_c) else $error("aux pin C not lost flag");

   property p_aux_d;
      aux_sel[1] == AUX_PASS |-> aux_pin_d == pattern_pass[1];
   endproperty
   a_aux_d: assert property (p_aux_d) else $error("aux pin D not pass flag");

   property p_aux_or;
      glob_cfg[BIT_AUX_HI] |-> aux_sel[0][1] && aux_sel[1][1];
   endproperty
   a_aux_or: assert property (p_aux_or) else $error("global aux bit ignored");

   property p_sigdet;
      !glob_cfg[BIT_SIGDET] |-> sig_det_en == '0;
   endproperty
   a_sigdet: assert property (p_sigdet) else $error("detect enabled against global");

   property p_strap_lock;
      wr_ok && hit_c && cfg_strap_high_bit |=> $stable(cfg_q[0][BIT_CFG1]);
   endproperty
   a_strap_lock: assert property (p_strap_lock) else $error("locked config bit changed");

   property p_pat_lock;
      wr_ok && hit_d && pattern_test_pin |=> $stable(cfg_q[1][BIT_PAT]);
   endproperty
   a_pat_lock: assert property (p_pat_lock) else $error("locked pattern bit changed");

   property p_align;
      align_en[0] |-> align_enable_pin && glob_cfg[BIT_ALIGN] && cfg_q[0][BIT_ALIGN];
   endproperty
   a_align: assert property (p_align) else $error("align enabled wrongly");

   property p_pdn_loop;
      base_ctrl[BASE_PDN] && base_ctrl[BASE_LOOP] |-> power_down == '1 && loopback == '1;
   endproperty
   a_pdn_loop: assert property (p_pdn_loop) else $error("base control not applied");

   property p_lost_clear;
      stat_rd && lost_taken_r[0] && !signal_absent_evt[0] |=> !lost_r[0];
   endproperty
   a_lost_clear: assert property (p_lost_clear) else $error("lost flag not cleared by read");

   property p_lost_set;
      signal_absent_evt[1] |=> lost_r[1];
   endproperty
   a_lost_set: assert property (p_lost_set) else $error("lost event dropped");

   property p_rsvd_store;
      cfg_q[0][REG_W-1:BIT_CTC+1] == '0 && cfg_q[1][REG_W-1:BIT_CTC+1] == '0;
   endproperty
   a_rsvd_store: assert property (p_rsvd_store) else $error("reserved bits stored");

   property p_rd_lane_d;
      setup_ph && !pwrite && hit_d ##1 access_ph |-> prdata == DATA_W'(cfg_q[1]);
   endproperty
   a_rd_lane_d: assert property (p_rd_lane_d) else $error("lane D read data wrong");

   property p_aux_iostd;
      aux_sel[0] == AUX_IOSTD |-> aux_pin_c == io_std_hstl;
   endproperty
   a_aux_iostd: assert property (p_aux_iostd) else $error("aux pin C not io standard");

   property p_aux_comma;
      aux_sel[1] == AUX_COMMA |-> aux_pin_d == comma_det[1];
   endproperty
   a_aux_comma: assert property (p_aux_comma) else $error("aux pin D not comma flag");

   property p_sigdet_on;
      glob_cfg[BIT_SIGDET] |-> sig_det_en == {cfg_q[1][BIT_SIGDET], cfg_q[0][BIT_SIGDET]};
   endproperty
   a_sigdet_on: assert property (p_sigdet_on) else $error("detect enable not from lane bit");

   property p_cfg_or;
      glob_cfg[BIT_CFG0] |-> cfg_mode[0] && cfg_mode[2];
   endproperty
   a_cfg_or: assert property (p_cfg_or) else $error("global config bit ignored");

   property p_emph_or;
      glob_cfg[BIT_EMPH_HI] |-> emph[1] && emph[3];
   endproperty
   a_emph_or: assert property (p_emph_or) else $error("global emphasis bit ignored");

   property p_loop;
      !base_ctrl[BASE_LOOP] |-> loopback == {cfg_q[1][BIT_LOOP], cfg_q[0][BIT_LOOP]};
   endproperty
   a_loop: assert property (p_loop) else $error("loopback not from lane bit");

   property p_pat_or;
      glob_cfg[BIT_PAT] |-> pattern_en == '1;
   endproperty
   a_pat_or: assert property (p_pat_or) else $error("global pattern bit ignored");

   property p_pdn;
      !base_ctrl[BASE_PDN] |-> power_down == {cfg_q[1][BIT_PDN], cfg_q[0][BIT_PDN]};
   endproperty
   a_pdn: assert property (p_pdn) else $error("power-down not from lane bit");

   property p_unmapped;
      access_ph && !pwrite && !hit_any |-> pslverr && prdata == '0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");

   c_wr_d:     cover property (wr_ok && hit_d);
   c_stat_rd:  cover property (stat_rd && lost_taken_r != '0);
   c_err:      cover property (pslverr);
   c_set_clr:  cover property (stat_rd && signal_absent_evt[0]);
   c_aux_lost: cover property (aux_sel[1] == AUX_LOST && aux_pin_d);

endmodule : lcr_regs
`default_nettype wire

// file: verification/lane_cd_config_regs_tb_top.sv
// Self-checking bench for the lane C/D configuration register bank.
// Assumes the APB slave answers with zero wait states and one 40 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module lane_cd_config_regs_tb_top
   import lcr_pkg::*;
;
   logic                   ref_clk, arst_n, psel, penable, pwrite;
   logic [ADDR_W-1:0]      paddr;
   logic [DATA_W-1:0]      pwdata, prdata;
   logic                   pready, pslverr;
   logic [REG_W-1:0]       glob_cfg, base_ctrl;
   logic                   cfg_strap_high_bit, cfg_strap_low_bit, pattern_test_pin, align_enable_pin, io_std_hstl;
   logic [NUM_LANES-1:0]   comma_det, signal_absent_evt, pattern_pass;
   logic                   aux_pin_c, aux_pin_d;
   logic [NUM_LANES-1:0]   ctc_en, sig_det_en, loopback, pattern_en, align_en, power_down;
   logic [2*NUM_LANES-1:0] cfg_mode, emph;
   logic [15:0]            m_reg [2];
   logic [1:0]             m_lost;
   logic [7:0]             lane_addr [2];
   logic [31:0]            rd;
   logic                   er;
   logic [15:0]            lock;
   int                     err_count, n_checks, cyc, l;

   lcr_regs dut (.ref_clk(ref_clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .glob_cfg(glob_cfg), .base_ctrl(base_ctrl), .cfg_strap_high_bit(cfg_strap_high_bit),
      .cfg_strap_low_bit(cfg_strap_low_bit), .pattern_test_pin(pattern_test_pin),
      .align_enable_pin(align_enable_pin), .io_std_hstl(io_std_hstl), .comma_det(comma_det),
      .signal_absent_evt(signal_absent_evt), .pattern_pass(pattern_pass), .aux_pin_c(aux_pin_c),
      .aux_pin_d(aux_pin_d), .ctc_en(ctc_en), .sig_det_en(sig_det_en), .cfg_mode(cfg_mode), .emph(emph),
      .loopback(loopback), .pattern_en(pattern_en), .align_en(align_en), .power_down(power_down));

   // ----------------------------------------------------------------
   // Clock and hang guard
   // ----------------------------------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 5000) begin
         err_count++;
         $display("mismatch at %0t: run did not finish", $time);
         end_sim();
      end
   end

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic end_sim;
      $display("checks %0d, mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : end_sim

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : cmp

   // One APB transfer; holds the request until pready is seen high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Model write honouring reserved bits and the strap locks
   task automatic lane_write(input int ln, input logic [31:0] d);
      apb(1'b1, lane_addr[ln], d);
      lock = {8'h00, cfg_strap_high_bit, cfg_strap_low_bit, 3'b000, pattern_test_pin, 2'b00};
      m_reg[ln] = (m_reg[ln] & lock) | (d[15:0] & 16'h0fff & ~lock);
   endtask : lane_write

   task automatic check_out;
      logic [1:0] s, ax, ctc, sd, lp, pt, al, pd;
      logic [3:0] cm, em;
      @(negedge ref_clk);
      for (int i = 0; i < 2; i++) begin
         s       = m_reg[i][10:9] | glob_cfg[10:9];
         ax[i]   = (s == 2'd0) ? io_std_hstl : (s == 2'd1) ? comma_det[i] :
                   (s == 2'd2) ? m_lost[i] : pattern_pass[i];
         ctc[i]  = m_reg[i][11] | glob_cfg[11];
         sd[i]   = m_reg[i][8] & glob_cfg[8];
         cm[2*i+:2] = m_reg[i][7:6] | glob_cfg[7:6];
         em[2*i+:2] = m_reg[i][5:4] | glob_cfg[5:4];
         lp[i]   = m_reg[i][3] | base_ctrl[14];
         pt[i]   = m_reg[i][2] | glob_cfg[2];
         al[i]   = m_reg[i][1] & align_enable_pin & glob_cfg[1];
         pd[i]   = m_reg[i][0] | base_ctrl[11];
      end
      cmp(32'({aux_pin_d, aux_pin_c, ctc_en, sig_det_en, cfg_mode, emph, loopback, pattern_en, align_en,
               power_down}), 32'({ax, ctc, sd, cm, em, lp, pt, al, pd}), "lane controls");
   endtask : check_out

   task automatic rand_in;
      @(posedge ref_clk);
      glob_cfg           <= 16'($urandom);
      base_ctrl          <= 16'($urandom);
      {cfg_strap_high_bit, cfg_strap_low_bit, pattern_test_pin} <= 3'($urandom);
      {align_enable_pin, io_std_hstl} <= 2'($urandom);
      comma_det          <= 2'($urandom);
      pattern_pass       <= 2'($urandom);
   endtask : rand_in

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      arst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
      glob_cfg = 16'hffff; base_ctrl = 16'h0000; cfg_strap_high_bit = 1'b0; cfg_strap_low_bit = 1'b0;
      pattern_test_pin = 1'b0; align_enable_pin = 1'b1; io_std_hstl = 1'b1; comma_det = 2'b00;
      signal_absent_evt = 2'b00; pattern_pass = 2'b00;
      m_reg[0] = 16'h0102; m_reg[1] = 16'h0102; m_lost = 2'b00;
      lane_addr[0] = LANE_C_ADDR; lane_addr[1] = LANE_D_ADDR;
      void'($urandom(32'h3acd));
      repeat (3) @(posedge ref_clk);
      arst_n <= 1'b1;
      for (int i = 0; i < 2; i++) begin
         apb(1'b0, lane_addr[i], 32'h0);
         cmp(rd, 32'h0000_0102, "reset value");
      end
      check_out();
      // Random writes with random globals, straps and pins
      repeat (60) begin
         rand_in();
         l = int'($urandom % 2);
         lane_write(l, $urandom);
         check_out();
         apb(1'b0, lane_addr[l], 32'h0);
         cmp(rd, {16'h0, m_reg[l]}, "read back");
      end
      // Every aux select code on both lanes, global select bits clear
      for (int c = 0; c < 4; c++) begin
         @(posedge ref_clk);
         glob_cfg <= 16'($urandom) & 16'hf9ff;
         for (int i = 0; i < 2; i++) lane_write(i, (32'(c) << 9) | ($urandom & 32'h01ff));
         check_out();
         @(posedge ref_clk);
         io_std_hstl  <= ~io_std_hstl;
         comma_det    <= ~comma_det;
         pattern_pass <= ~pattern_pass;
         check_out();
      end
      // Sticky signal-lost flags: set by event, cleared by a status read
      for (int i = 0; i < 2; i++) lane_write(i, 32'h0000_0502);
      @(posedge ref_clk);
      signal_absent_evt <= 2'b11;
      @(posedge ref_clk);
      signal_absent_evt <= 2'b00;
      m_lost = 2'b11;
      check_out();
      repeat (2) begin
         apb(1'b0, LANE_STAT_ADDR, 32'h0);
         cmp(rd, 32'({pattern_pass, 2'b00, m_lost, 2'b00}), "status");
         m_lost = 2'b00;
         check_out();
      end
      // Unmapped places refuse and leave lane C alone
      apb(1'b1, 8'h54, 32'hffff_ffff);
      cmp(32'({pready, er}), 32'h3, "unmapped write error");
      apb(1'b0, 8'h54, 32'h0);
      cmp(rd, 32'h0, "unmapped read data");
      cmp(32'(er), 32'h1, "unmapped read error");
      apb(1'b0, LANE_C_ADDR, 32'h0);
      cmp(rd, {16'h0, m_reg[0]}, "lane C after unmapped");
      // Reset in mid-run: lanes and sticky flags return to defaults
      for (int i = 0; i < 2; i++) lane_write(i, $urandom);
      @(posedge ref_clk);
      signal_absent_evt <= 2'b11;
      @(posedge ref_clk);
      signal_absent_evt <= 2'b00;
      arst_n            <= 1'b0;
      repeat (3) @(posedge ref_clk);
      arst_n <= 1'b1;
      m_reg[0] = 16'h0102;
      m_reg[1] = 16'h0102;
      m_lost   = 2'b00;
      check_out();
      for (int i = 0; i < 2; i++) begin
         apb(1'b0, lane_addr[i], 32'h0);
         cmp(rd, 32'h0000_0102, "value after mid-run reset");
      end
      apb(1'b0, LANE_STAT_ADDR, 32'h0);
      cmp(rd, 32'({pattern_pass, 2'b00, m_lost, 2'b00}), "status after reset");
      end_sim();
   end
endmodule : lane_cd_config_regs_tb_top
`default_nettype wire
